// ### pkg/wdg_pkg.sv
// Constants shared by the digital watchdog and its reset-entry logic.
// Assumes one clock, which is the oscillator clock of the core.
`default_nettype none
package wdg_pkg;
    // Register map, byte address on the AHB-Lite bus
    localparam logic [31:0] WDR_ADDR     = 32'h0000_00D8;
    localparam logic [7:0]  WDR_RESET    = 8'hFE;
    // Bit positions of the watchdog register
    localparam int          C_POS        = 0;
    localparam int          SOFT_RST_POS = 1;
    localparam int          CNT_MSB_POS  = 7;
    localparam int          CNT_W        = 6;
    localparam int          TMR_W        = 7;
    // Timer values: full count, and the value whose next step drops the soft reset bit
    localparam logic [6:0]  TMR_FULL     = 7'h7F;
    localparam logic [6:0]  TMR_EDGE     = 7'h40;
    // Prescaler: one timer step every 3072 oscillator cycles
    localparam int          PRESC_W      = 12;
    localparam logic [11:0] PRESC_LAST   = 12'hBFF;
    // Instructions that run after activation before a timeout may reset
    localparam logic [4:0]  GUARD_INSTR  = 5'h1C;
    // Stabilisation delay applied after every reset, in clock cycles
    localparam int          STAB_CYCLES  = 32'h0000_1000;
    localparam int          STAB_W       = 16;
    // Program memory address of the reset vector
    localparam logic [11:0] RESET_VECTOR = 12'hFFE;
    // AHB-Lite encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
endpackage : wdg_pkg
`default_nettype wire

// ### rtl/wdg_prescaler.sv
// Fixed prescaler that paces the watchdog timer.
// Assumes run is low while the oscillator is stopped.
`default_nettype none
module wdg_prescaler
    import wdg_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Control
    input  wire logic run,
    input  wire logic restart,
    // Step enable
    output logic      tick
);
    logic [PRESC_W-1:0] count;

    // Last cycle of each period
    wire logic at_last = (count == PRESC_LAST);

    // Count oscillator cycles, pulse once per period
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (restart) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            tick <= run && at_last;
            if (run) begin
                count <= at_last ? '0 : PRESC_W'(count + 1'b1);
            end
        end
    end
endmodule : wdg_prescaler
`default_nettype wire

// ### rtl/wdg_reset_seq.sv
// Internal reset stretcher: holds the core in reset for the stabilisation delay.
// Assumes trigger is a one-cycle pulse from logic on the same clock.
`default_nettype none
module wdg_reset_seq
    import wdg_pkg::*;
#(
    parameter int STAB = STAB_CYCLES
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Internal reset request
    input  wire logic trigger,
    // Reset state
    output logic      core_reset,
    output logic      release_p
);
    logic [STAB_W-1:0] wait_cnt;

    // End of the stabilisation delay
    wire logic done = (wait_cnt == STAB_W'(STAB - 1));

    // Restart the delay on every request, release once it expires
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            core_reset <= 1'b1;
            wait_cnt   <= '0;
            release_p  <= 1'b0;
        end else begin
            release_p <= 1'b0;
            if (trigger) begin
                core_reset <= 1'b1;
                wait_cnt   <= '0;
            end else if (core_reset) begin
                if (done) begin
                    core_reset <= 1'b0;
                    release_p  <= 1'b1;
                end else begin
                    wait_cnt <= STAB_W'(wait_cnt + 1'b1);
                end
            end
        end
    end
endmodule : wdg_reset_seq
`default_nettype wire

// ### rtl/digital_watchdog.sv
// Digital watchdog with reset-entry control of the core, on AHB-Lite.
// Assumes clk is the oscillator clock and the core reports its events as pulses.
`default_nettype none
module digital_watchdog
    import wdg_pkg::*;
#(
    parameter int STAB = STAB_CYCLES
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Build options, static
    input  wire logic        opt_hw_activate,
    input  wire logic        opt_ext_stop,
    // Pin and core events
    input  wire logic        nmi_pin,
    input  wire logic        instr_done,
    input  wire logic        stop_exec,
    input  wire logic        wake_irq,
    input  wire logic        return_exec,
    input  wire logic        irq_pending,
    // Reset entry to the core
    output logic             core_reset,
    output logic             stack_clear,
    output logic             vector_load,
    output logic [11:0]      reset_vector,
    output logic             nmi_mode,
    output logic             service_irq,
    output logic             resume_next,
    // Power state
    output logic             stop_mode,
    output logic             wait_mode,
    output logic             osc_run,
    output logic             wdg_active
);
    typedef enum {PWR_RUN, PWR_WAIT, PWR_STOP} pwr_t;

    logic             opt_hw;
    logic             opt_ext;
    logic             nmi_s1;
    logic             nmi_s2;
    logic             nmi_s3;
    logic             nmi_lvl;
    logic [TMR_W-1:0] tmr;
    logic             c_bit;
    logic [4:0]       instr_cnt;
    logic             ph_wr;
    pwr_t             pwr;
    pwr_t             next_pwr;
    logic             tick;
    logic             release_p;
    logic [7:0]       rd_val;
    logic [TMR_W-1:0] wr_tmr;

    // Bus decode
    wire logic addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
    wire logic hit     = addr_ok && hsize == HSIZE_WORD && haddr == WDR_ADDR;
    wire logic wr_en   = ph_wr;
    wire logic wr_c    = hwdata[C_POS];

    // Watchdog control terms
    wire logic active   = opt_hw | c_bit;
    wire logic guard_ok = instr_cnt >= GUARD_INSTR;
    wire logic at_edge  = tmr == TMR_EDGE;
    wire logic start    = wr_en && wr_c && !active;
    wire logic hold     = active && !guard_ok && at_edge;
    wire logic dec_en   = tick && !stop_mode && !hold;
    wire logic sw_reset = wr_en && tmr[TMR_W-1] && !hwdata[SOFT_RST_POS];
    wire logic exp_rst  = dec_en && !wr_en && at_edge && active;
    wire logic trigger  = sw_reset || exp_rst;

    // Reload wins over a step; inactive counter wraps as a plain timer
    wire logic [TMR_W-1:0] next_tmr = wr_en  ? wr_tmr :
                                      dec_en ? TMR_W'(tmr - 1'b1) :
                                      tmr;

    // Bit-reversed mapping between register and counter
    genvar gi;
    for (gi = 0; gi < CNT_W; gi++) begin : g_rev
        assign rd_val[CNT_MSB_POS - gi] = tmr[gi];
        assign wr_tmr[gi]               = hwdata[CNT_MSB_POS - gi];
    end
    assign rd_val[SOFT_RST_POS] = tmr[TMR_W-1];
    assign rd_val[C_POS]        = active;
    assign wr_tmr[TMR_W-1]      = hwdata[SOFT_RST_POS];

    // Prescaler, restarted by a reload so the period runs from the write
    wdg_prescaler wdg_prescaler_inst (
        .clk     (clk),
        .rst_b   (rst_b),
        .run     (!stop_mode),
        .restart (wr_en || core_reset),
        .tick    (tick)
    );

    // Reset stretcher shared by the pin reset and the watchdog
    wdg_reset_seq #(
        .STAB (STAB)
    ) wdg_reset_seq_inst (
        .clk        (clk),
        .rst_b      (rst_b),
        .trigger    (trigger),
        .core_reset (core_reset),
        .release_p  (release_p)
    );

    // Option straps, sampled while the core is held in reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            opt_hw  <= 1'b0;
            opt_ext <= 1'b0;
        end else if (core_reset) begin
            opt_hw  <= opt_hw_activate;
            opt_ext <= opt_ext_stop;
        end
    end

    // NMI pin synchroniser, level taken once two stages agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nmi_s1  <= 1'b0;
            nmi_s2  <= 1'b0;
            nmi_s3  <= 1'b0;
            nmi_lvl <= 1'b0;
        end else begin
            nmi_s1 <= nmi_pin;
            nmi_s2 <= nmi_s1;
            nmi_s3 <= nmi_s2;
            if (nmi_s2 == nmi_s3) begin
                nmi_lvl <= nmi_s3;
            end
        end
    end

    // Bus address phase: capture write intent and read data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_wr     <= 1'b0;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ph_wr     <= hit && hwrite;
            hrdata    <= (hit && !hwrite) ? {24'h0, rd_val} : '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Counter set to full count and activate bit cleared by every reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tmr   <= TMR_FULL;
            c_bit <= 1'b0;
        end else if (core_reset) begin
            tmr   <= TMR_FULL;
            c_bit <= 1'b0;
        end else begin
            tmr <= next_tmr;
            if (wr_en && wr_c) begin
                c_bit <= 1'b1;
            end
        end
    end

    // Instructions counted since activation
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instr_cnt <= '0;
        end else if (core_reset || start) begin
            instr_cnt <= '0;
        end else if (instr_done && !guard_ok) begin
            instr_cnt <= 5'(instr_cnt + 1'b1);
        end
    end

    // Stop instruction handling
    always_comb begin
        next_pwr = pwr;
        unique case (pwr)
            PWR_RUN: begin
                if (stop_exec) begin
                    if (!active || (opt_ext && nmi_lvl)) begin
                        next_pwr = PWR_STOP;
                    end else begin
                        next_pwr = PWR_WAIT;
                    end
                end
            end
            PWR_WAIT, PWR_STOP: begin
                if (wake_irq) begin
                    next_pwr = PWR_RUN;
                end
            end
        endcase
    end

    // Power state and its outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr       <= PWR_RUN;
            stop_mode <= 1'b0;
            wait_mode <= 1'b0;
            osc_run   <= 1'b1;
        end else begin
            pwr       <= core_reset ? PWR_RUN : next_pwr;
            stop_mode <= !core_reset && next_pwr == PWR_STOP;
            wait_mode <= !core_reset && next_pwr == PWR_WAIT;
            osc_run   <= core_reset || next_pwr != PWR_STOP;
        end
    end

    // Reset entry: vector load, stack clear, reset vector, active flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stack_clear  <= 1'b0;
            vector_load  <= 1'b0;
            reset_vector <= RESET_VECTOR;
            wdg_active   <= 1'b0;
        end else begin
            stack_clear  <= release_p;
            vector_load  <= release_p;
            reset_vector <= RESET_VECTOR;
            wdg_active   <= active && !core_reset;
        end
    end

    // Interrupt flag held from reset until the closing return
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nmi_mode    <= 1'b1;
            service_irq <= 1'b0;
            resume_next <= 1'b0;
        end else begin
            service_irq <= 1'b0;
            resume_next <= 1'b0;
            if (core_reset) begin
                nmi_mode <= 1'b1;
            end else if (return_exec && nmi_mode) begin
                nmi_mode    <= 1'b0;
                service_irq <= irq_pending;
                resume_next <= !irq_pending;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    vector_load_a:
    assert property (release_p |=> vector_load && stack_clear && reset_vector == RESET_VECTOR)
        else $error("reset vector not loaded on release");

    init_nmi_a:
    assert property (release_p |=> nmi_mode [*2])
        else $error("core not in non-maskable mode after reset");

    ret_choice_a:
    assert property (return_exec && nmi_mode && !core_reset
                     |=> !nmi_mode && service_irq == $past(irq_pending)
                         && resume_next == !$past(irq_pending))
        else $error("closing return took wrong path");

    expiry_reset_a:
    assert property (exp_rst |=> core_reset ##1 tmr == TMR_FULL)
        else $error("expiry did not reset the device");

    activate_sticky_a:
    assert property (c_bit && !core_reset |=> c_bit)
        else $error("activate bit cleared without reset");

    hw_activate_a:
    assert property (opt_hw && !core_reset |=> wdg_active && rd_val[C_POS])
        else $error("hardware option activate bit not one");

    true_stop_a:
    assert property (pwr == PWR_RUN && stop_exec && !active && !core_reset
                     |=> stop_mode && !osc_run)
        else $error("disabled watchdog did not allow stop");

    stop_as_wait_a:
    assert property (pwr == PWR_RUN && stop_exec && opt_hw && !opt_ext && !core_reset
                     |=> wait_mode && osc_run && !stop_mode)
        else $error("stop not taken as wait");

    stop_freeze_a:
    assert property (stop_mode && !wr_en && !core_reset |=> $stable(tmr))
        else $error("counter moved during stop");

    wake_resume_a:
    assert property (pwr == PWR_STOP && wake_irq && !core_reset |=> !stop_mode && osc_run)
        else $error("interrupt did not leave stop");

    reset_value_a:
    assert property ($fell(core_reset) |-> tmr == TMR_FULL && !c_bit
                     && rd_val[7:1] == WDR_RESET[7:1])
        else $error("register not at reset value");

    soft_reset_a:
    assert property (sw_reset |=> core_reset)
        else $error("soft reset bit clear did not reset");

    bit_order_a:
    assert property (rd_val[CNT_MSB_POS] == tmr[0] && rd_val[2] == tmr[CNT_W-1])
        else $error("count bits not reversed");

    guard_hold_a:
    assert property (tick && hold && !wr_en && !stop_mode && !core_reset |=> at_edge)
        else $error("timeout before guard instructions");

    step_down_a:
    assert property (dec_en && !wr_en && !core_reset |=> tmr == TMR_W'($past(tmr) - 1'b1))
        else $error("counter did not step down by one");

    read_back_a:
    assert property (hit && !hwrite |=> hrdata[7:0] == $past(rd_val) && hrdata[31:8] == '0)
        else $error("read data does not match state");
endmodule : digital_watchdog
`default_nettype wire

// ### verification/core_model.sv
// Behavioural processor core running user firmware: retires instructions, raises events.
// Assumes the watchdog block shares its clock and reports core_reset as a level.
`default_nettype none
module core_model (
    // Clock and core reset state
    input  wire logic clk,
    input  wire logic core_reset,
    // Events towards the watchdog
    output logic      nmi_pin,
    output logic      instr_done,
    output logic      stop_exec,
    output logic      wake_irq,
    output logic      return_exec,
    output logic      irq_pending
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet core at time zero
    initial begin
        nmi_pin     = 1'b0;
        instr_done  = 1'b0;
        stop_exec   = 1'b0;
        wake_irq    = 1'b0;
        return_exec = 1'b0;
        irq_pending = 1'b0;
    end

    // One event pulse: 0 instruction, 1 stop, 2 wake, 3 return; none while held in reset
    task automatic event_pulse(input int kind, input logic pend);
        @(posedge clk);
        while (core_reset !== 1'b0) @(posedge clk);
        instr_done  <= (kind == 0);
        stop_exec   <= (kind == 1);
        wake_irq    <= (kind == 2);
        return_exec <= (kind == 3);
        irq_pending <= pend;
        @(posedge clk);
        instr_done  <= 1'b0;
        stop_exec   <= 1'b0;
        wake_irq    <= 1'b0;
        return_exec <= 1'b0;
        irq_pending <= ~pend;  // Opposite level once the return is taken
    endtask : event_pulse

    // Firmware loop retiring plain instructions
    task automatic run_instr(input int n);
        repeat (n) event_pulse(0, 1'b0);
    endtask : run_instr

    // External stop control level on the interrupt pin
    task automatic set_nmi(input logic v);
        @(posedge clk);
        nmi_pin <= v;
    endtask : set_nmi
endmodule : core_model
`default_nettype wire

// ### verification/digital_watchdog_reset_init_tb.sv
// Self-checking bench for the digital watchdog with its AHB-Lite register port.
// Assumes the core model drives the event pins; STAB is shortened to 8 cycles.
`default_nettype none
module digital_watchdog_reset_init_tb
    import wdg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst_b, hsel, hwrite, hreadyout, hresp, rd_pend;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        opt_hw_activate, opt_ext_stop, nmi_pin, instr_done, stop_exec;
    logic        wake_irq, return_exec, irq_pending, core_reset, stack_clear, vector_load;
    logic [11:0] reset_vector;
    logic        nmi_mode, service_irq, resume_next, stop_mode, wait_mode, osc_run;
    logic        wdg_active, seen;
    logic [6:0]  tval;
    wire         hready;
    int          mismatches, checks, seed_val;
    logic [31:0] exp_q[$];

    assign hready = hreadyout;

    digital_watchdog #(.STAB(8)) digital_watchdog_inst (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .opt_hw_activate(opt_hw_activate), .opt_ext_stop(opt_ext_stop),
        .nmi_pin(nmi_pin), .instr_done(instr_done), .stop_exec(stop_exec),
        .wake_irq(wake_irq), .return_exec(return_exec), .irq_pending(irq_pending),
        .core_reset(core_reset), .stack_clear(stack_clear), .vector_load(vector_load),
        .reset_vector(reset_vector), .nmi_mode(nmi_mode), .service_irq(service_irq),
        .resume_next(resume_next), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .osc_run(osc_run), .wdg_active(wdg_active));

    core_model core_model_inst (
        .clk(clk), .core_reset(core_reset), .nmi_pin(nmi_pin), .instr_done(instr_done),
        .stop_exec(stop_exec), .wake_irq(wake_irq), .return_exec(return_exec),
        .irq_pending(irq_pending));

    // Clock at 125 MHz
    always #4 clk = ~clk;

    // Compare and count
    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        checks++;
        if (seen_v !== exp_v) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    endtask : check

    task automatic chk1(input logic s, input logic e);
        check({31'h0, s}, {31'h0, e});
    endtask : chk1

    // Verdict and end of run
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // Register byte from a timer value: count bits reversed, timer MSB in bit 1
    function automatic logic [7:0] enc(input logic [6:0] t, input logic c);
        logic [7:0] v;
        v[0] = c;
        v[1] = t[6];
        for (int i = 0; i < 6; i++) begin
            v[7 - i] = t[i];
        end
        return v;
    endfunction : enc

    // One AHB-Lite single transfer; for a read, d is the expected data
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        if (!wr) begin
            exp_q.push_back(d);
            rd_pend <= 1'b1;
        end
        do @(posedge clk); while (hready !== 1'b1);
        rd_pend <= 1'b0;
    endtask : bus

    // Read data monitor: oldest expectation against the data phase
    always @(posedge clk) begin
        if (rd_pend === 1'b1 && hready === 1'b1) begin
            check(hrdata, exp_q.pop_front());
            check({31'h0, hresp}, 32'h0);
        end
    end

    // Watch up to n cycles for core_reset to be high, return as soon as it is
    task automatic wait_rst(input int n);
        seen = 1'b0;
        for (int i = 0; i < n && !seen; i++) begin
            @(negedge clk);
            seen |= (core_reset === 1'b1);
        end
    endtask : wait_rst

    // Reset release: vector fetch pulses, non-maskable mode, closing return
    task automatic post_reset();
        logic p;
        p    = 1'($urandom);
        seen = 1'b0;
        do begin
            @(negedge clk);
            seen |= (stack_clear === 1'b1) && (vector_load === 1'b1);
        end while (core_reset !== 1'b0);
        repeat (3) begin
            @(negedge clk);
            seen |= (stack_clear === 1'b1) && (vector_load === 1'b1);
        end
        chk1(seen, 1'b1);
        check({20'h0, reset_vector}, {20'h0, RESET_VECTOR});
        chk1(nmi_mode, 1'b1);
        core_model_inst.event_pulse(3, p);
        @(negedge clk);
        chk1(service_irq, p);
        chk1(resume_next, ~p);
        chk1(nmi_mode, 1'b0);
        core_model_inst.event_pulse(3, 1'b1);
        @(negedge clk);
        chk1(service_irq | resume_next, 1'b0);
    endtask : post_reset

    task automatic do_reset(input logic hw, input logic ext);
        @(posedge clk);
        rst_b           <= 1'b0;
        opt_hw_activate <= hw;
        opt_ext_stop    <= ext;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        post_reset();
    endtask : do_reset

    // Stop instruction, then check the power state one cycle on
    task automatic stop_chk(input logic st, input logic wt);
        core_model_inst.event_pulse(1, 1'b0);
        @(negedge clk);
        chk1(stop_mode, st);
        chk1(wait_mode, wt);
        chk1(osc_run, ~st);
    endtask : stop_chk

    task automatic wake_chk();
        core_model_inst.event_pulse(2, 1'b0);
        @(negedge clk);
        chk1(stop_mode | wait_mode, 1'b0);
        chk1(osc_run, 1'b1);
    endtask : wake_chk

    // Hang guard, well beyond the expected 13k cycles
    initial begin
        #(40000 * 8);
        mismatches++;
        test_done();
    end

    // Main sequence
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        rd_pend = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        opt_hw_activate = 1'b0;
        opt_ext_stop = 1'b0;
        mismatches = 0;
        checks = 0;
        seed_val = $urandom(32'hECFD5101);
        do_reset(1'b0, 1'b0);
        bus(1'b0, WDR_ADDR, 32'hFE);
        bus(1'b0, 32'hDC, 32'h0);
        bus(1'b1, 32'hDC, 32'h0);
        bus(1'b0, WDR_ADDR, 32'hFE);
        chk1(wdg_active, 1'b0);
        $display("test reset_values done");
        repeat (4) begin
            tval = {1'b1, 6'($urandom)};
            bus(1'b1, WDR_ADDR, {24'h0, enc(tval, 1'b0)});
            bus(1'b0, WDR_ADDR, {24'h0, enc(tval, 1'b0)});
        end
        bus(1'b1, WDR_ADDR, {24'h0, enc(7'h45, 1'b0)});
        repeat (3100) @(posedge clk);
        bus(1'b0, WDR_ADDR, {24'h0, enc(7'h44, 1'b0)});
        stop_chk(1'b1, 1'b0);
        wake_chk();
        $display("test timer_and_stop done");
        bus(1'b1, WDR_ADDR, 32'hFC);
        wait_rst(3);
        chk1(seen, 1'b1);
        post_reset();
        bus(1'b0, WDR_ADDR, 32'hFE);
        $display("test soft_reset done");
        bus(1'b1, WDR_ADDR, 32'h03);
        bus(1'b1, WDR_ADDR, 32'h02);
        bus(1'b0, WDR_ADDR, 32'h03);
        chk1(wdg_active, 1'b1);
        wait_rst(3200);
        chk1(seen, 1'b0);
        bus(1'b0, WDR_ADDR, 32'h03);
        core_model_inst.run_instr(28);
        wait_rst(3300);
        chk1(seen, 1'b1);
        post_reset();
        bus(1'b0, WDR_ADDR, 32'hFE);
        chk1(wdg_active, 1'b0);
        $display("test expiry done");
        do_reset(1'b1, 1'b0);
        bus(1'b0, WDR_ADDR, 32'hFF);
        bus(1'b1, WDR_ADDR, 32'hFE);
        bus(1'b0, WDR_ADDR, 32'hFF);
        chk1(wdg_active, 1'b1);
        stop_chk(1'b0, 1'b1);
        wake_chk();
        $display("test hw_option done");
        do_reset(1'b1, 1'b1);
        core_model_inst.set_nmi(1'b1);
        repeat (6) @(posedge clk);
        stop_chk(1'b1, 1'b0);
        bus(1'b0, WDR_ADDR, 32'hFF);
        repeat (3200) @(posedge clk);
        bus(1'b0, WDR_ADDR, 32'hFF);
        wake_chk();
        core_model_inst.set_nmi(1'b0);
        repeat (6) @(posedge clk);
        stop_chk(1'b0, 1'b1);
        wake_chk();
        $display("test ext_stop done");
        test_done();
    end
endmodule : digital_watchdog_reset_init_tb
`default_nettype wire
